// ### cdt_timers_map.vh
`ifndef CDT_TIMERS_MAP_VH
`define CDT_TIMERS_MAP_VH

// Register byte addresses
`define CDT_ADDR_W            5
`define CDT_OFS_CONTROL       5'h00
`define CDT_OFS_A_COUNT       5'h04
`define CDT_OFS_B_COUNT       5'h08
`define CDT_OFS_A_RELOAD      5'h0C
`define CDT_OFS_B_RELOAD      5'h10
`define CDT_OFS_A_IRQ_CTRL    5'h14
`define CDT_OFS_B_IRQ_CTRL    5'h18

// Control register fields, timer A in low byte, timer B in high byte
`define CDT_A_SEL_HI          2
`define CDT_A_SEL_LO          0
`define CDT_A_MODE_BIT        3
`define CDT_A_RUN_BIT         6
`define CDT_B_SEL_HI          10
`define CDT_B_SEL_LO          8
`define CDT_B_MODE_BIT        11
`define CDT_B_RUN_BIT         14
`define CDT_CONTROL_MASK      16'h4F4F

// Interrupt control register fields
`define CDT_IRQ_FLAG_BIT      7
`define CDT_IRQ_ENABLE_BIT    6
`define CDT_IRQ_CTRL_MASK     16'h00C0

// Reset values
`define CDT_CONTROL_RESET     16'h0000
`define CDT_COUNT_RESET       16'h0000
`define CDT_RELOAD_RESET      16'h0000
`define CDT_ZERO16            16'h0000
`define CDT_ZERO32            32'h0000_0000
`define CDT_ZERO8             8'h00
`define CDT_ZERO6             6'h00
`define CDT_STRB_NONE         4'h0
`define CDT_COUNT_MAX         16'hFFFF
`define CDT_COUNT_ONE         16'h0001

// Timing: one state is two clock periods; base divide of 16 clocks is 8 states
`define CDT_PRESCALE_W        10
`define CDT_PRESCALE_FULL     10'h3FF
`define CDT_SEL_MAX           3'h7
`define CDT_PRESCALE_ONE      10'h001

// Counter-mode selection codes (low two bits)
`define CDT_SEL_AUX           2'b00
`define CDT_SEL_RISE          2'b01
`define CDT_SEL_FALL          2'b10
`define CDT_SEL_BOTH          2'b11

// AXI responses
`define CDT_RESP_OKAY         2'b00
`define CDT_RESP_SLVERR       2'b10

`endif

// ### cdt_timers.v
// How it works
// - Control low byte timer A, high byte timer B
// - Mode bits 3 and 11: timer or counter
// - Run bits 6 and 14 start or halt
// - Three-bit input select fields per timer
// - Both timers only count upward
// - Software count write beats same-state increment
// - Timer mode rate is clock over 16*2^sel
// - Select codes give divide 16 up to 2048
// - Wrap from FFFFh loads the reload register
// - Increments spaced exactly one resolution interval
// - Timer A serviced one state before B
// - Counter select X00 counts auxiliary timer events
// - Timer B other counter selects stop it
// - Timer A counts pin rise, fall or both
// - Pin edge appears in count within eight states
// - Pin sampled even when driven as output
// - Overflow sets flag; enable raises request
// - Separate irq control and request per timer
// - One state equals two clock periods
// - Reserved control bits read as zero
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cdt_timers_map.vh"

module cdt_timers (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [4:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [4:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        timer_a_event_pin_in,
  input  wire        aux_timer_six_event_in,
  output reg  [15:0] timer_a_count_out,
  output reg  [15:0] timer_b_count_out,
  output reg         timer_a_irq_out,
  output reg         timer_b_irq_out
);

  // Merge byte lanes of a write into a 16-bit register
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  wstrb;
    begin
      merge16[7:0]  = wstrb[0] ? wdata[7:0]  : old_val[7:0];
      merge16[15:8] = wstrb[1] ? wdata[15:8] : old_val[15:8];
    end
  endfunction

  // Prescaler mask: 8 states times 2^sel
  function [`CDT_PRESCALE_W-1:0] rate_mask;
    input [2:0] sel;
    begin
      rate_mask = `CDT_PRESCALE_FULL >> (`CDT_SEL_MAX - sel);
    end
  endfunction

  // Timer mode match: low 3+sel prescaler bits all ones
  function rate_hit;
    input [`CDT_PRESCALE_W-1:0] count;
    input [2:0]                 sel;
    begin
      rate_hit = (count & rate_mask(sel)) == rate_mask(sel);
    end
  endfunction

  // Interrupt control word: flag and enable, all other bits zero
  function [31:0] irq_word;
    input flag;
    input enable;
    begin
      irq_word = {`CDT_ZERO16, `CDT_ZERO8, flag, enable, `CDT_ZERO6};
    end
  endfunction

  // Offset belongs to one of the seven registers
  function addr_mapped;
    input [4:0] addr;
    begin
      addr_mapped = (addr == `CDT_OFS_CONTROL)  || (addr == `CDT_OFS_A_COUNT)  ||
                    (addr == `CDT_OFS_B_COUNT)  || (addr == `CDT_OFS_A_RELOAD) ||
                    (addr == `CDT_OFS_B_RELOAD) || (addr == `CDT_OFS_A_IRQ_CTRL) ||
                    (addr == `CDT_OFS_B_IRQ_CTRL);
    end
  endfunction

  reg  [15:0] control_reg;
  reg  [15:0] a_reload_reg;
  reg  [15:0] b_reload_reg;
  reg         a_flag_reg;
  reg         a_enable_reg;
  reg         b_flag_reg;
  reg         b_enable_reg;

  reg         state_phase_reg;
  reg  [`CDT_PRESCALE_W-1:0] prescale_reg;
  reg         pin_sync1_reg;
  reg         pin_sync2_reg;
  reg         pin_prev_reg;
  reg         pin_rise_pend_reg;
  reg         pin_fall_pend_reg;
  reg         aux_pend_reg;
  reg         b_due_reg;

  reg  [4:0]  aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;

  // Control field views
  wire [2:0]  a_sel  = control_reg[`CDT_A_SEL_HI:`CDT_A_SEL_LO];
  wire        a_mode = control_reg[`CDT_A_MODE_BIT];
  wire        a_run  = control_reg[`CDT_A_RUN_BIT];
  wire [2:0]  b_sel  = control_reg[`CDT_B_SEL_HI:`CDT_B_SEL_LO];
  wire        b_mode = control_reg[`CDT_B_MODE_BIT];
  wire        b_run  = control_reg[`CDT_B_RUN_BIT];

  // AXI write and read address channel acceptance
  assign s_axi_awready_out = !aw_held_reg && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held_reg && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  wire        aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire        w_take  = s_axi_wvalid_in && s_axi_wready_out;
  wire        aw_have = aw_held_reg || aw_take;
  wire        w_have  = w_held_reg || w_take;
  wire        wr_go   = aw_have && w_have;
  wire [4:0]  wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr_in;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata_in;
  wire [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb_in;
  wire        rd_go   = s_axi_arvalid_in && s_axi_arready_out;

  wire        wr_ctrl  = wr_go && (wr_addr == `CDT_OFS_CONTROL);
  wire        wr_a_cnt = wr_go && (wr_addr == `CDT_OFS_A_COUNT);
  wire        wr_b_cnt = wr_go && (wr_addr == `CDT_OFS_B_COUNT);
  wire        wr_a_rel = wr_go && (wr_addr == `CDT_OFS_A_RELOAD);
  wire        wr_b_rel = wr_go && (wr_addr == `CDT_OFS_B_RELOAD);
  wire        wr_a_irq = wr_go && (wr_addr == `CDT_OFS_A_IRQ_CTRL);
  wire        wr_b_irq = wr_go && (wr_addr == `CDT_OFS_B_IRQ_CTRL);
  wire        wr_known = addr_mapped(wr_addr);
  // Irq control bits sit in the low byte only
  wire        wr_a_irq_lo = wr_a_irq && wr_strb[0];
  wire        wr_b_irq_lo = wr_b_irq && wr_strb[0];

  // State boundary: one strobe every two clocks
  wire        state_tick = state_phase_reg;
  wire        pin_rise   = pin_sync2_reg && !pin_prev_reg;
  wire        pin_fall   = !pin_sync2_reg && pin_prev_reg;

  // Timer A source for this state
  reg         a_event;
  always @* begin
    a_event = 1'b0;
    if (!a_mode) begin
      a_event = rate_hit(prescale_reg, a_sel);
    end else begin
      case (a_sel[1:0])
        `CDT_SEL_AUX:  a_event = aux_pend_reg;
        `CDT_SEL_RISE: a_event = pin_rise_pend_reg;
        `CDT_SEL_FALL: a_event = pin_fall_pend_reg;
        default:       a_event = pin_rise_pend_reg || pin_fall_pend_reg;
      endcase
    end
  end

  // Timer B source for this state
  reg         b_event;
  always @* begin
    b_event = 1'b0;
    if (!b_mode) begin
      b_event = rate_hit(prescale_reg, b_sel);
    end else if (b_sel[1:0] == `CDT_SEL_AUX) begin
      b_event = aux_pend_reg;
    end else begin
      b_event = 1'b0;
    end
  end

  wire        a_step = state_tick && a_run && a_event && !wr_a_cnt;
  // A count write in the stepping state drops that step or reload
  wire        b_step = state_tick && b_due_reg && b_run && !wr_b_cnt;
  wire        a_wrap = a_step && (timer_a_count_out == `CDT_COUNT_MAX);
  wire        b_wrap = b_step && (timer_b_count_out == `CDT_COUNT_MAX);

  // State phase and prescaler
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_phase_reg <= 1'b0;
      prescale_reg    <= {`CDT_PRESCALE_W{1'b0}};
      b_due_reg       <= 1'b0;
    end else begin
      state_phase_reg <= !state_phase_reg;
      if (state_tick) begin
        prescale_reg  <= prescale_reg + `CDT_PRESCALE_ONE;
        // B is due now and serviced one state after A
        b_due_reg     <= b_run && b_event;
      end
    end
  end

  // Pin synchroniser, edge catch and aux event catch
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_sync1_reg     <= 1'b0;
      pin_sync2_reg     <= 1'b0;
      pin_prev_reg      <= 1'b0;
      pin_rise_pend_reg <= 1'b0;
      pin_fall_pend_reg <= 1'b0;
      aux_pend_reg      <= 1'b0;
    end else begin
      pin_sync1_reg <= timer_a_event_pin_in;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg  <= pin_sync2_reg;
      // Catch edges between strobes so none is lost
      if (state_tick) begin
        pin_rise_pend_reg <= pin_rise;
        pin_fall_pend_reg <= pin_fall;
        aux_pend_reg      <= aux_timer_six_event_in;
      end else begin
        pin_rise_pend_reg <= pin_rise_pend_reg || pin_rise;
        pin_fall_pend_reg <= pin_fall_pend_reg || pin_fall;
        aux_pend_reg      <= aux_pend_reg || aux_timer_six_event_in;
      end
    end
  end

  // Counters, reloads and control
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      control_reg       <= `CDT_CONTROL_RESET;
      timer_a_count_out <= `CDT_COUNT_RESET;
      timer_b_count_out <= `CDT_COUNT_RESET;
      a_reload_reg      <= `CDT_RELOAD_RESET;
      b_reload_reg      <= `CDT_RELOAD_RESET;
    end else begin
      if (wr_ctrl) begin
        control_reg <= merge16(control_reg, wr_data, wr_strb) & `CDT_CONTROL_MASK;
      end
      if (wr_a_rel) begin
        a_reload_reg <= merge16(a_reload_reg, wr_data, wr_strb);
      end
      if (wr_b_rel) begin
        b_reload_reg <= merge16(b_reload_reg, wr_data, wr_strb);
      end
      // Software write first, then reload on wrap, then plain step
      if (wr_a_cnt) begin
        timer_a_count_out <= merge16(timer_a_count_out, wr_data, wr_strb);
      end else if (a_wrap) begin
        timer_a_count_out <= a_reload_reg;
      end else if (a_step) begin
        timer_a_count_out <= timer_a_count_out + `CDT_COUNT_ONE;
      end
      if (wr_b_cnt) begin
        timer_b_count_out <= merge16(timer_b_count_out, wr_data, wr_strb);
      end else if (b_wrap) begin
        timer_b_count_out <= b_reload_reg;
      end else if (b_step) begin
        timer_b_count_out <= timer_b_count_out + `CDT_COUNT_ONE;
      end
    end
  end

  // Interrupt flags and enables, one set per timer
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      a_flag_reg      <= 1'b0;
      a_enable_reg    <= 1'b0;
      b_flag_reg      <= 1'b0;
      b_enable_reg    <= 1'b0;
      timer_a_irq_out <= 1'b0;
      timer_b_irq_out <= 1'b0;
    end else begin
      // Overflow set wins over a same-cycle software clear
      if (a_wrap) begin
        a_flag_reg <= 1'b1;
      end else if (wr_a_irq_lo) begin
        a_flag_reg <= wr_data[`CDT_IRQ_FLAG_BIT];
      end
      if (b_wrap) begin
        b_flag_reg <= 1'b1;
      end else if (wr_b_irq_lo) begin
        b_flag_reg <= wr_data[`CDT_IRQ_FLAG_BIT];
      end
      if (wr_a_irq_lo) begin
        a_enable_reg <= wr_data[`CDT_IRQ_ENABLE_BIT];
      end
      if (wr_b_irq_lo) begin
        b_enable_reg <= wr_data[`CDT_IRQ_ENABLE_BIT];
      end
      timer_a_irq_out <= a_flag_reg && a_enable_reg;
      timer_b_irq_out <= b_flag_reg && b_enable_reg;
    end
  end

  // AXI write path
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_held_reg      <= 1'b0;
      aw_addr_reg      <= `CDT_OFS_CONTROL;
      w_held_reg       <= 1'b0;
      w_data_reg       <= `CDT_ZERO32;
      w_strb_reg       <= `CDT_STRB_NONE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `CDT_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_known ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr_in;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata_in;
          w_strb_reg <= s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
          s_axi_bvalid_out <= 1'b0;
        end
      end
    end
  end

  // AXI read path
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= `CDT_ZERO32;
      s_axi_rresp_out  <= `CDT_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= addr_mapped(s_axi_araddr_in) ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
      if (s_axi_araddr_in == `CDT_OFS_CONTROL) begin
        s_axi_rdata_out <= {`CDT_ZERO16, control_reg};
      end else if (s_axi_araddr_in == `CDT_OFS_A_COUNT) begin
        s_axi_rdata_out <= {`CDT_ZERO16, timer_a_count_out};
      end else if (s_axi_araddr_in == `CDT_OFS_B_COUNT) begin
        s_axi_rdata_out <= {`CDT_ZERO16, timer_b_count_out};
      end else if (s_axi_araddr_in == `CDT_OFS_A_RELOAD) begin
        s_axi_rdata_out <= {`CDT_ZERO16, a_reload_reg};
      end else if (s_axi_araddr_in == `CDT_OFS_B_RELOAD) begin
        s_axi_rdata_out <= {`CDT_ZERO16, b_reload_reg};
      end else if (s_axi_araddr_in == `CDT_OFS_A_IRQ_CTRL) begin
        s_axi_rdata_out <= irq_word(a_flag_reg, a_enable_reg);
      end else if (s_axi_araddr_in == `CDT_OFS_B_IRQ_CTRL) begin
        s_axi_rdata_out <= irq_word(b_flag_reg, b_enable_reg);
      end else begin
        s_axi_rdata_out <= `CDT_ZERO32;
      end
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // cdt_timers

`default_nettype wire

// ### cdt_timers_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cdt_timers_assertions (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [15:0] timer_a_count_out,
  input wire logic [15:0] timer_b_count_out,
  input wire logic        timer_a_irq_out,
  input wire logic        timer_b_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] a_prev;
  logic [15:0] b_prev;
  logic        bv_prev;
  always_ff @(posedge clk_in) begin
    a_prev  <= timer_a_count_out;
    b_prev  <= timer_b_count_out;
    bv_prev <= s_axi_bvalid_out;
  end
  // Register write landed, or a count left FFFF
  wire logic bv_rise = s_axi_bvalid_out & ~bv_prev;
  wire logic wrap_a  = (a_prev == 16'hFFFF) && (timer_a_count_out != a_prev);
  wire logic wrap_b  = (b_prev == 16'hFFFF) && (timer_b_count_out != b_prev);
  sequence a_step;
    (timer_a_count_out != a_prev) && !bv_rise;
  endsequence
  sequence b_step;
    (timer_b_count_out != b_prev) && !bv_rise;
  endsequence
  chk_a_counts_up: assert property (
    a_step |-> wrap_a || timer_a_count_out == a_prev + 16'h0001)
    else $error("timer a step not plus one");
  chk_b_counts_up: assert property (
    b_step |-> wrap_b || timer_b_count_out == b_prev + 16'h0001)
    else $error("timer b step not plus one");
  chk_a_state_spaced: assert property (
    a_step ##1 !bv_rise |-> timer_a_count_out == a_prev)
    else $error("timer a stepped on two clocks in a row");
  chk_b_state_spaced: assert property (
    b_step ##1 !bv_rise |-> timer_b_count_out == b_prev)
    else $error("timer b stepped on two clocks in a row");
  chk_irq_a_cause: assert property (
    $rose(timer_a_irq_out) |-> $past(wrap_a) || $past(bv_rise))
    else $error("timer a request without cause");
  chk_irq_b_cause: assert property (
    $rose(timer_b_irq_out) |-> $past(wrap_b) || $past(bv_rise))
    else $error("timer b request without cause");
  chk_reset_clear: assert property (
    $rose(rst_n_in) |-> timer_a_count_out == 16'h0000 && timer_b_count_out == 16'h0000
      && !timer_a_irq_out && !timer_b_irq_out)
    else $error("outputs not clear after reset");
  chk_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out
      && s_axi_rdata_out[31:16] == 16'h0000)
    else $error("read answer late or upper half set");
endmodule // cdt_timers_assertions
bind cdt_timers cdt_timers_assertions chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
  .timer_a_count_out(timer_a_count_out), .timer_b_count_out(timer_b_count_out),
  .timer_a_irq_out(timer_a_irq_out), .timer_b_irq_out(timer_b_irq_out));
`default_nettype wire

// ### cdt_event_source.sv
`timescale 1ns/1ps
`default_nettype none
module cdt_event_source (
  input  wire logic clk_in,
  output var logic  event_pin_out,
  output var logic  aux_event_out
);
  initial begin
    event_pin_out = 1'b0;
    aux_event_out = 1'b0;
  end
  // New pin level, held no shorter than eight states
  task automatic set_pin(input logic lvl, input int hold);
    @(posedge clk_in);
    event_pin_out <= lvl;
    repeat (hold < 16 ? 16 : hold) @(posedge clk_in);
  endtask
  // One auxiliary timer overflow
  task automatic aux_pulse();
    @(posedge clk_in);
    aux_event_out <= 1'b1;
    @(posedge clk_in);
    aux_event_out <= 1'b0;
  endtask
endmodule // cdt_event_source
`default_nettype wire

// ### cdt_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdt_timers_map.vh"
module cdt_timers_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h3;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, pin, aux, irq_a, irq_b;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] cnt_a, cnt_b;
  int miscompares = 0;
  int compares = 0;
  int n;
  int e;
  logic [31:0] rd;
  logic [31:0] keep;
  logic [1:0] rsp;
  always #5 clk_in = ~clk_in;
  cdt_timers dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .timer_a_event_pin_in(pin), .aux_timer_six_event_in(aux),
    .timer_a_count_out(cnt_a), .timer_b_count_out(cnt_b), .timer_a_irq_out(irq_a),
    .timer_b_irq_out(irq_b));
  cdt_event_source far_u (.clk_in(clk_in), .event_pin_out(pin), .aux_event_out(aux));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes sampled at the falling edge, acted on at the rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_hit;
    logic w_hit;
    logic b_hit = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit) begin
      @(negedge clk_in);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      rsp = bresp;
      @(posedge clk_in);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    logic ar_hit;
    logic r_hit = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit) begin
      @(negedge clk_in);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge clk_in);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    #1;
  endtask
  // Cycles until the chosen count next changes
  task automatic gap(input logic use_b);
    logic [15:0] prev;
    prev = use_b ? cnt_b : cnt_a;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((use_b ? cnt_b : cnt_a) === prev && n < 5000);
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a <= 28; a += 4) begin
      rd_reg(5'(a));
      check(rd, 32'h0000_0000);
      check(32'(rsp), a == 28 ? `CDT_RESP_SLVERR : `CDT_RESP_OKAY);
    end
    wr(5'h1C, 32'h0000_FFFF);
    check(32'(rsp), `CDT_RESP_SLVERR);
    wr(`CDT_OFS_CONTROL, 32'hFFFF_FFFF);
    rd_reg(`CDT_OFS_CONTROL);
    check(rd, 32'h0000_4F4F);
    $display("register test done");
    for (int s = 0; s < 8; s++) begin
      wr(`CDT_OFS_CONTROL, 32'h0000_0040 | 32'(s));
      gap(1'b0);
      check(32'(n <= (16 << s)), 32'h0000_0001);
      gap(1'b0);
      check(32'(n), 32'(16 << s));
    end
    wr(`CDT_OFS_CONTROL, 32'h0000_4040);
    gap(1'b0);
    gap(1'b1);
    check(32'(n), 32'h0000_0002);
    gap(1'b1);
    check(32'(n), 32'h0000_0010);
    wr(`CDT_OFS_CONTROL, 32'h0000_0040);
    gap(1'b0);
    repeat (14) @(posedge clk_in);
    wr(`CDT_OFS_A_COUNT, 32'h0000_0ABC);
    check(32'(cnt_a), 32'h0000_0ABC);
    gap(1'b0);
    check(32'(cnt_a), 32'h0000_0ABD);
    wr(`CDT_OFS_CONTROL, 32'h0000_0000);
    rd_reg(`CDT_OFS_A_COUNT);
    keep = rd;
    repeat (40) @(posedge clk_in);
    rd_reg(`CDT_OFS_A_COUNT);
    check(rd, keep);
    $display("timer mode test done");
    for (int t = 0; t < 2; t++) begin
      wr(5'(`CDT_OFS_A_RELOAD + 4 * t), 32'h0000_1234);
      wr(5'(`CDT_OFS_A_COUNT + 4 * t), 32'h0000_FFFE);
      wr(5'(`CDT_OFS_A_IRQ_CTRL + 4 * t), 32'h0000_0040);
      wr(`CDT_OFS_CONTROL, t ? 32'h0000_4000 : 32'h0000_0040);
      gap(t[0]);
      check(32'(n <= 16 + 2 * t), 32'h0000_0001);
      gap(t[0]);
      check(32'(t ? cnt_b : cnt_a), 32'h0000_1234);
      repeat (3) @(negedge clk_in);
      check({30'h0, irq_b, irq_a}, t ? 32'h2 : 32'h1);
      rd_reg(5'(`CDT_OFS_A_IRQ_CTRL + 4 * t));
      check(rd, 32'h0000_00C0);
      wr(5'(`CDT_OFS_A_IRQ_CTRL + 4 * t), 32'h0000_0080);
      repeat (3) @(negedge clk_in);
      check({30'h0, irq_b, irq_a}, 32'h0);
      wr(`CDT_OFS_CONTROL, 32'h0000_0000);
    end
    $display("reload test done");
    for (int s = 1; s < 4; s++) begin
      wr(`CDT_OFS_A_COUNT, 32'h0000_0000);
      wr(`CDT_OFS_CONTROL, 32'h0000_0048 | 32'(s));
      e = 0;
      for (int i = 0; i < 4; i++) begin
        far_u.set_pin(~i[0], 16 + 24 * i[1]);
        e += i[0] ? s >> 1 : s & 1;
        @(negedge clk_in);
        check(32'(cnt_a), 32'(e));
      end
    end
    $display("pin count test done");
    wr(`CDT_OFS_A_COUNT, 32'h0000_0000);
    wr(`CDT_OFS_B_COUNT, 32'h0000_0000);
    wr(`CDT_OFS_CONTROL, 32'h0000_4C48);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(`CDT_OFS_CONTROL, 32'h0000_4948);
      far_u.aux_pulse();
      repeat (6) @(negedge clk_in);
      check({cnt_b, cnt_a}, {16'(i < 3 ? i + 1 : 3), 16'(i + 1)});
    end
    $display("aux count test done");
    complete_run();
  end
endmodule // cdt_timers_tb
`default_nettype wire
